/* File: hdl/line_diff.sv */
// Purpose: Output differentiation and hysteresis input for a group of lines.
// Assumes: far_oe marks the bits the other end drives this cycle.
// Notes: Output and enable come from flip-flops, one cycle after the value.
`timescale 1ns/1ns
module line_diff #(
	parameter int W = 8
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic diff_on,
	input wire logic drive_en,
	input wire logic [W-1:0] out_val,
	input wire logic [W-1:0] far_val,
	input wire logic [W-1:0] far_oe,
	output logic [W-1:0] pin_o,
	output logic [W-1:0] pin_oe,
	output logic [W-1:0] in_val
);
	logic [W-1:0] last_reg;
	logic [W-1:0] hold_reg;
	logic own_reg;

	generate
		if (W < 1) begin : g_chk
			$error("line_diff needs at least one line");
		end
	endgenerate

	// Drive on a change only, or always when differentiation is off or in the first driven cycle.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_o <= '0;
			pin_oe <= '0;
			last_reg <= '0;
			own_reg <= 1'b0;
		end else begin
			pin_o <= out_val;
			last_reg <= out_val;
			own_reg <= drive_en;
			if (!drive_en)
				pin_oe <= '0;
			else if (!diff_on || !own_reg)
				pin_oe <= '1;
			else
				pin_oe <= out_val ^ last_reg;
		end
	end

	// A floating line keeps the level last driven onto it.
	always_ff @(posedge sys_clk) begin
		if (srst)
			hold_reg <= '0;
		else
			hold_reg <= in_val;
	end

	// Per-bit choice between the driven level and the held one.
	always_comb begin
		for (int i = 0; i < W; i++) begin
			in_val[i] = far_oe[i] ? far_val[i] : hold_reg[i];
		end
	end
endmodule

/* File: hdl/link_end_ctrl.sv */
// Purpose: Link-controller end: request serializer, transmit after grant,
//   receive and status capture.
// Assumes: Transmit bytes are offered as valid with a last marker.
// Notes: The reserved control code is never driven.
`timescale 1ns/1ns
module link_end_ctrl #(
	parameter int STAT_BITS = phy_link_pkg::STAT_W
) (
	input wire logic sys_clk,
	input wire logic srst,
	link_if.link_end lk,
	input wire logic diff_on,
	input wire logic req_valid,
	input wire logic [2:0] req_kind,
	input wire logic [phy_link_pkg::ARG_W-1:0] req_arg,
	output logic req_ready_reg,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready_reg,
	output logic rx_valid_reg,
	output logic [7:0] rx_data_reg,
	output logic stat_valid_reg,
	output logic [STAT_BITS-1:0] stat_word_reg
);
	import phy_link_pkg::*;

	localparam int STEPS = STAT_BITS / 2;
	localparam int SC_W = $clog2(STEPS + 1);

	typedef enum logic [1:0] {
		L_PHY = 2'b00,
		L_SEND = 2'b01,
		L_DONE = 2'b10
	} lst_t;

	generate
		if (STAT_BITS % 2 != 0 || STAT_BITS < 2) begin : g_chk
			$error("link_end_ctrl status width must be even");
		end
	endgenerate

	lst_t st_reg;
	logic [1:0] ctl_val, ctl_in;
	logic [7:0] d_in;
	logic [16:0] ser_reg;
	logic [4:0] left_reg;
	logic [SC_W-1:0] sc_reg;
	logic take;

	assign take = st_reg == L_SEND && tx_valid && tx_ready_reg;
	assign ctl_val = st_reg == L_SEND ?
		(take ? LC_TRANSMIT : LC_HOLD) : LC_IDLE;

	// Pins of this end, differentiated when isolation is used.
	line_diff #(.W(2)) u_ctl (.sys_clk(sys_clk), .srst(srst),
		.diff_on(diff_on), .drive_en(st_reg != L_PHY),
		.out_val(ctl_val), .far_val(lk.phy_ctl_o), .far_oe(lk.phy_ctl_oe),
		.pin_o(lk.llc_ctl_o), .pin_oe(lk.llc_ctl_oe), .in_val(ctl_in));
	line_diff #(.W(8)) u_dat (.sys_clk(sys_clk), .srst(srst),
		.diff_on(diff_on), .drive_en(st_reg != L_PHY),
		.out_val(take ? tx_data : 8'h00), .far_val(lk.phy_d_o),
		.far_oe(lk.phy_d_oe), .pin_o(lk.llc_d_o), .pin_oe(lk.llc_d_oe),
		.in_val(d_in));
	line_diff #(.W(1)) u_req (.sys_clk(sys_clk), .srst(srst),
		.diff_on(diff_on), .drive_en(1'b1), .out_val(ser_reg[16]),
		.far_val(1'b0), .far_oe(1'b0), .pin_o(lk.link_request_line_o),
		.pin_oe(lk.link_request_line_oe), .in_val());

	// Request serializer, start bit first, line low when done.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ser_reg <= 17'h00000;
			left_reg <= 5'h00;
			req_ready_reg <= 1'b0;
		end else if (req_valid && req_ready_reg) begin
			req_ready_reg <= 1'b0;
			unique case (req_kind)
				RQ_RD: begin
					ser_reg <= {1'b1, req_kind, req_arg[3:0], 9'h000};
					left_reg <= LEN_RD;
				end
				RQ_WR: begin
					ser_reg <= {1'b1, req_kind, req_arg[11:0], 1'b0};
					left_reg <= LEN_WR;
				end
				RQ_ACCEL: begin
					ser_reg <= {1'b1, req_kind, req_arg[0], 12'h000};
					left_reg <= LEN_ACCEL;
				end
				default: begin
					ser_reg <= {1'b1, req_kind, req_arg[2:0], 10'h000};
					left_reg <= LEN_BUS;
				end
			endcase
		end else if (left_reg != 5'h00) begin
			ser_reg <= {ser_reg[15:0], 1'b0};
			left_reg <= 5'(left_reg - 1'b1);
			req_ready_reg <= left_reg == 5'h01;
		end else begin
			req_ready_reg <= 1'b1;
		end
	end

	// Ownership: take the buses on a grant, release with one idle code.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_reg <= L_PHY;
			tx_ready_reg <= 1'b0;
		end else begin
			unique case (st_reg)
				L_PHY: begin
					// A held grant level after our own release is stale.
					if (ctl_in == PC_GRANT && lk.phy_ctl_oe != 2'b00) begin
						st_reg <= L_SEND;
						tx_ready_reg <= 1'b1;
					end
				end
				L_SEND: begin
					if (take && tx_last) begin
						st_reg <= L_DONE;
						tx_ready_reg <= 1'b0;
					end
				end
				default: st_reg <= L_PHY;
			endcase
		end
	end

	// Receive bytes and status words from the other end.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_valid_reg <= 1'b0;
			rx_data_reg <= 8'h00;
			stat_valid_reg <= 1'b0;
			stat_word_reg <= '0;
			sc_reg <= '0;
		end else begin
			rx_valid_reg <= st_reg == L_PHY && ctl_in == PC_RECEIVE;
			rx_data_reg <= d_in;
			stat_valid_reg <= 1'b0;
			if (st_reg == L_PHY && ctl_in == PC_STATUS) begin
				stat_word_reg <= {stat_word_reg[STAT_BITS-3:0], d_in[1:0]};
				sc_reg <= SC_W'(sc_reg + 1'b1);
				if (sc_reg == SC_W'(STEPS - 1)) begin
					stat_valid_reg <= 1'b1;
					sc_reg <= '0;
				end
			end else begin
				sc_reg <= '0;
			end
		end
	end
endmodule

/* File: hdl/link_if.sv */
// Purpose: Wires between the transceiver end and the link-controller end.
// Assumes: Each driver gives a value and a per-bit output enable.
// Notes: A receiver holds the last driven level while a line floats.
`timescale 1ns/1ns
interface link_if;
	logic [1:0] phy_ctl_o;
	logic [1:0] phy_ctl_oe;
	logic [7:0] phy_d_o;
	logic [7:0] phy_d_oe;
	logic [1:0] llc_ctl_o;
	logic [1:0] llc_ctl_oe;
	logic [7:0] llc_d_o;
	logic [7:0] llc_d_oe;
	logic link_request_line_o;
	logic link_request_line_oe;
	modport phy_end (
		output phy_ctl_o, phy_ctl_oe, phy_d_o, phy_d_oe,
		input llc_ctl_o, llc_ctl_oe, llc_d_o, llc_d_oe, link_request_line_o, link_request_line_oe
	);
	modport link_end (
		input phy_ctl_o, phy_ctl_oe, phy_d_o, phy_d_oe,
		output llc_ctl_o, llc_ctl_oe, llc_d_o, llc_d_oe, link_request_line_o, link_request_line_oe
	);
endinterface

/* File: hdl/phy_end_ctrl.sv */
// Purpose: Transceiver end of the link interface: control pair encoding,
//   status, receive and grant sequencing, request stream decoding.
// Assumes: All pins sampled on the rising interface clock edge.
// Notes: Received bytes pass a two-entry buffer before the data lanes.
// What this block and the link end do
// - Status transfer autonomous or answering register read.
// - Each arriving packet starts a receive operation.
// - Won arbitration grants interface to link controller.
// - Own codes: idle, status, receive, grant.
// - Link codes: release, hold, transmit; 11 reserved.
// - Isolation select low enables output differentiation.
// - Differentiated output drives one clock per change.
// - Hysteresis inputs keep level of floating line.
// - Differentiate control and data; hysteresis on request.
// - Link differentiates outputs, hysteresis on its inputs.
// - Link shifts requests serially, one bit per clock.
// - Lengths: bus 7/8, read 9, write 17, accel 6.
// - Start 1, type next, stop 0, line rests low.
// - Decode type field into seven request kinds.
// - Immediate request takes bus at idle, no arbitration.
// - Isochronous request arbitrates at idle, no gap.
// - Priority/fair arbitrate after gap; fair obeys fairness.
// - Read answers by status, write stores, accel sets enable bit.
// - Bus request speed in bits 4-6, stop optional.
// - Speed codes S100, S200, S400; others invalid.
// - Invalid speed accepted; link data dropped, null sent.
// - Everything sampled on rising interface clock edge.
// - Link drives shared buses only after grant.
`timescale 1ns/1ns
module phy_end_ctrl #(
	parameter int STAT_BITS = phy_link_pkg::STAT_W,
	parameter int REG_CNT = 16
) (
	input wire logic sys_clk,
	input wire logic srst,
	link_if.phy_end lk,
	input wire logic iso_sel,
	input wire logic stat_req,
	input wire logic [STAT_BITS-1:0] stat_word,
	input wire logic rx_in_valid,
	input wire logic [7:0] rx_in_data,
	input wire logic rx_in_last,
	output logic rx_in_ready_reg,
	input wire logic arb_won,
	output logic bus_pend_reg,
	output logic arb_skip_reg,
	output logic arb_no_gap_reg,
	output logic arb_gap_reg,
	output logic fair_rule_reg,
	output logic [2:0] speed_reg,
	output logic accel_en_reg,
	output logic tx_valid_reg,
	output logic [7:0] tx_data_reg,
	output logic null_tx_reg
);
	import phy_link_pkg::*;

	localparam int STEPS = STAT_BITS / 2;
	localparam int SC_W = $clog2(STEPS + 1);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_STATUS = 3'b001,
		ST_RECV = 3'b010,
		ST_GRANT = 3'b011,
		ST_LINK = 3'b100
	} st_t;

	generate
		if (STAT_BITS % 2 != 0 || STAT_BITS <= ADDR_W + DATA_W ||
			REG_CNT > 16 || REG_CNT < 1) begin : g_chk
			$error("phy_end_ctrl parameters out of range");
		end
	endgenerate

	st_t st_reg, st_next;
	logic [1:0] ctl_val, ctl_in;
	logic [7:0] d_val, d_in;
	logic link_request_line_in;
	logic seen_reg, won_reg;
	logic [DATA_W-1:0] regs [REG_CNT];
	logic [4:0] cnt_reg;
	logic [15:0] sh_reg;
	logic [2:0] type_reg;
	logic rx_during_reg;
	logic done;
	logic rd_pend_reg, auto_pend_reg, send_rd_reg;
	logic [ADDR_W-1:0] rd_addr_reg;
	logic [STAT_BITS-1:0] auto_reg, stat_sh_reg;
	logic [SC_W-1:0] sc_reg;
	logic [8:0] buf_mem [2];
	logic wp_reg, rp_reg;
	logic [1:0] fill_reg, fill_next;
	logic push, pop, rx_avail, stat_end;
	logic speed_bad_reg;

	// Speed codes that the serial side can send.
	function automatic logic speed_ok(input logic [2:0] sp);
		return sp == SP_S100 || sp == SP_S200 || sp == SP_S400;
	endfunction

	// Total stream length for a request type; a reserved stream is read
	// to its end like a bus request, so its tail never looks like a start.
	function automatic logic [4:0] req_len(input logic [2:0] t);
		unique case (t)
			RQ_RD: req_len = LEN_RD;
			RQ_WR: req_len = LEN_WR;
			RQ_ACCEL: req_len = LEN_ACCEL;
			default: req_len = LEN_BUS;
		endcase
	endfunction

	// Pins: differentiated control pair and data, hysteresis on requests.
	line_diff #(.W(2)) u_ctl (.sys_clk(sys_clk), .srst(srst),
		.diff_on(!iso_sel), .drive_en(st_reg != ST_LINK),
		.out_val(ctl_val), .far_val(lk.llc_ctl_o), .far_oe(lk.llc_ctl_oe),
		.pin_o(lk.phy_ctl_o), .pin_oe(lk.phy_ctl_oe), .in_val(ctl_in));
	line_diff #(.W(8)) u_dat (.sys_clk(sys_clk), .srst(srst),
		.diff_on(!iso_sel), .drive_en(st_reg != ST_LINK),
		.out_val(d_val), .far_val(lk.llc_d_o), .far_oe(lk.llc_d_oe),
		.pin_o(lk.phy_d_o), .pin_oe(lk.phy_d_oe), .in_val(d_in));
	line_diff #(.W(1)) u_req (.sys_clk(sys_clk), .srst(srst),
		.diff_on(!iso_sel), .drive_en(1'b0), .out_val(1'b0),
		.far_val(lk.link_request_line_o), .far_oe(lk.link_request_line_oe),
		.pin_o(), .pin_oe(), .in_val(link_request_line_in));

	// Two-entry buffer in front of the receive path.
	assign rx_avail = fill_reg != 2'h0;
	assign push = rx_in_valid && rx_in_ready_reg;
	assign pop = st_reg == ST_RECV && rx_avail;
	assign fill_next = 2'(fill_reg + {1'b0, push} - {1'b0, pop});
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fill_reg <= 2'h0;
			wp_reg <= 1'b0;
			rp_reg <= 1'b0;
			rx_in_ready_reg <= 1'b0;
		end else begin
			fill_reg <= fill_next;
			rx_in_ready_reg <= fill_next != 2'h2;
			if (push)
				wp_reg <= !wp_reg;
			if (pop)
				rp_reg <= !rp_reg;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (push)
			buf_mem[wp_reg] <= {rx_in_last, rx_in_data};
	end

	assign stat_end = st_reg == ST_STATUS && !rx_avail &&
		sc_reg == SC_W'(STEPS - 1);

	// Interface ownership sequencing; a packet preempts a status transfer.
	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			ST_IDLE: begin
				if (rx_avail)
					st_next = ST_RECV;
				else if (won_reg)
					st_next = ST_GRANT;
				else if (rd_pend_reg || auto_pend_reg)
					st_next = ST_STATUS;
			end
			ST_STATUS: begin
				if (rx_avail)
					st_next = ST_RECV;
				else if (stat_end)
					st_next = ST_IDLE;
			end
			ST_RECV: begin
				if (pop && buf_mem[rp_reg][8])
					st_next = ST_IDLE;
			end
			ST_GRANT: st_next = ST_LINK;
			ST_LINK: begin
				if (seen_reg && ctl_in == LC_IDLE)
					st_next = ST_IDLE;
			end
			default: st_next = ST_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (srst)
			st_reg <= ST_IDLE;
		else
			st_reg <= st_next;
	end

	// Control pair and data lane values while this end owns the buses.
	always_comb begin
		ctl_val = PC_IDLE;
		d_val = 8'h00;
		unique case (st_reg)
			ST_STATUS: begin
				ctl_val = PC_STATUS;
				d_val = {6'h00, stat_sh_reg[STAT_BITS-1 -: 2]};
			end
			ST_RECV: begin
				ctl_val = PC_RECEIVE;
				d_val = pop ? buf_mem[rp_reg][7:0] : 8'h00;
			end
			ST_GRANT: ctl_val = PC_GRANT;
			default: ctl_val = PC_IDLE;
		endcase
	end

	// Status shifter, two bits per cycle; restarted after a preemption.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sc_reg <= '0;
			stat_sh_reg <= '0;
			send_rd_reg <= 1'b0;
		end else if (st_reg != ST_STATUS && st_next == ST_STATUS) begin
			sc_reg <= '0;
			send_rd_reg <= rd_pend_reg;
			if (rd_pend_reg)
				stat_sh_reg <= {rd_addr_reg, regs[rd_addr_reg],
					(STAT_BITS - ADDR_W - DATA_W)'(0)};
			else
				stat_sh_reg <= auto_reg;
		end else if (st_reg == ST_STATUS) begin
			sc_reg <= SC_W'(sc_reg + 1'b1);
			stat_sh_reg <= {stat_sh_reg[STAT_BITS-3:0], 2'b00};
		end
	end

	// Autonomous status request; a new request wins over completion.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			auto_pend_reg <= 1'b0;
			auto_reg <= '0;
		end else if (stat_req) begin
			auto_pend_reg <= 1'b1;
			auto_reg <= stat_word;
		end else if (stat_end && !send_rd_reg) begin
			auto_pend_reg <= 1'b0;
		end
	end

	// Request stream shift register and bit counter.
	assign done = cnt_reg > TYPE_DONE_BIT &&
		(cnt_reg == req_len(type_reg) - 5'h01 ||
		(type_reg[2] == 1'b0 && cnt_reg == LEN_BUS_SHORT &&
		!sh_reg[0] && link_request_line_in));
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_reg <= 5'h00;
			sh_reg <= 16'h0000;
			type_reg <= RQ_IMM;
			rx_during_reg <= 1'b0;
		end else begin
			if (cnt_reg == 5'h00 || done) begin
				cnt_reg <= {4'h0, link_request_line_in};
				rx_during_reg <= 1'b0;
			end else begin
				cnt_reg <= 5'(cnt_reg + 1'b1);
				sh_reg <= {sh_reg[14:0], link_request_line_in};
				if (st_reg == ST_RECV)
					rx_during_reg <= 1'b1;
			end
			if (cnt_reg == TYPE_DONE_BIT)
				type_reg <= {sh_reg[1:0], link_request_line_in};
		end
	end

	// Bus request bookkeeping for the serial-side arbiter.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bus_pend_reg <= 1'b0;
			arb_skip_reg <= 1'b0;
			arb_no_gap_reg <= 1'b0;
			arb_gap_reg <= 1'b0;
			fair_rule_reg <= 1'b0;
			speed_reg <= SP_S100;
			speed_bad_reg <= 1'b0;
			won_reg <= 1'b0;
		end else begin
			if (done && type_reg[2] == 1'b0 && !bus_pend_reg &&
				!(rx_during_reg && type_reg[1])) begin
				bus_pend_reg <= 1'b1;
				arb_skip_reg <= type_reg == RQ_IMM;
				arb_no_gap_reg <= type_reg == RQ_ISO;
				arb_gap_reg <= type_reg[1];
				fair_rule_reg <= type_reg == RQ_FAIR;
				speed_reg <= sh_reg[2:0];
				speed_bad_reg <= !speed_ok(sh_reg[2:0]);
			end else if (st_reg == ST_GRANT ||
				(st_next == ST_RECV && arb_gap_reg)) begin
				bus_pend_reg <= 1'b0;
				arb_gap_reg <= 1'b0;
				arb_skip_reg <= 1'b0;
				arb_no_gap_reg <= 1'b0;
			end
			if (arb_won && bus_pend_reg)
				won_reg <= 1'b1;
			else if (st_reg == ST_GRANT)
				won_reg <= 1'b0;
		end
	end

	// Register access and acceleration control requests.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_pend_reg <= 1'b0;
			rd_addr_reg <= '0;
			accel_en_reg <= 1'b1;
		end else begin
			if (done && type_reg == RQ_RD && !rd_pend_reg) begin
				rd_pend_reg <= 1'b1;
				rd_addr_reg <= sh_reg[ADDR_W-1:0];
			end else if (stat_end && send_rd_reg) begin
				rd_pend_reg <= 1'b0;
			end
			if (done && type_reg == RQ_ACCEL)
				accel_en_reg <= sh_reg[0];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < REG_CNT; i++)
				regs[i] <= '0;
		end else if (done && type_reg == RQ_WR &&
			int'(sh_reg[11:8]) < REG_CNT) begin
			regs[sh_reg[11:8]] <= sh_reg[7:0];
		end
	end

	// Link transmit path; an invalid speed turns the packet into a null one.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			seen_reg <= 1'b0;
			null_tx_reg <= 1'b0;
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 8'h00;
		end else begin
			seen_reg <= st_reg == ST_LINK &&
				(seen_reg || lk.llc_ctl_oe != 2'b00);
			if (st_reg == ST_GRANT)
				null_tx_reg <= speed_bad_reg;
			// The first driven cycle of the link counts, not only later ones.
			tx_valid_reg <= st_reg == ST_LINK && ctl_in == LC_TRANSMIT &&
				(seen_reg || lk.llc_ctl_oe != 2'b00) &&
				!null_tx_reg;
			tx_data_reg <= d_in;
		end
	end
endmodule

/* File: hdl/phy_link_pkg.sv */
// Purpose: Shared constants for the transceiver to link-controller interface.
// Assumes: One interface clock shared by both ends.
// Notes: Request streams are sent start bit first, most significant first.
package phy_link_pkg;
	// Bench clock period in ns; the real interface clock is 49.152 MHz.
	localparam real IF_CLK_NS = 4.0;
	// Control pair codes, one type for each owner of the pair.
	typedef enum logic [1:0] {
		PC_IDLE = 2'b00,
		PC_STATUS = 2'b01,
		PC_RECEIVE = 2'b10,
		PC_GRANT = 2'b11
	} phy_ctl_t;
	typedef enum logic [1:0] {
		LC_IDLE = 2'b00,
		LC_HOLD = 2'b01,
		LC_TRANSMIT = 2'b10,
		LC_RESERVED = 2'b11
	} llc_ctl_t;
	// Request type field codes.
	localparam logic [2:0] RQ_IMM = 3'h0;
	localparam logic [2:0] RQ_ISO = 3'h1;
	localparam logic [2:0] RQ_PRI = 3'h2;
	localparam logic [2:0] RQ_FAIR = 3'h3;
	localparam logic [2:0] RQ_RD = 3'h4;
	localparam logic [2:0] RQ_WR = 3'h5;
	localparam logic [2:0] RQ_ACCEL = 3'h6;
	localparam logic [2:0] RQ_RSVD = 3'h7;
	// Stream lengths in bits, start and stop included; LEN_BUS_SHORT is a bus stream without stop.
	localparam logic [4:0] LEN_BUS = 5'h08;
	localparam logic [4:0] LEN_BUS_SHORT = 5'h07;
	localparam logic [4:0] LEN_RD = 5'h09;
	localparam logic [4:0] LEN_WR = 5'h11;
	localparam logic [4:0] LEN_ACCEL = 5'h06;
	localparam logic [4:0] TYPE_DONE_BIT = 5'h03;
	// Speed field codes.
	localparam logic [2:0] SP_S100 = 3'h0;
	localparam logic [2:0] SP_S200 = 3'h2;
	localparam logic [2:0] SP_S400 = 3'h4;
	// Status word width, register address width and data width.
	localparam int STAT_W = 16;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int ARG_W = 12;
endpackage

/* File: testbench/phy_link_checker.sv */
// Purpose: Concurrent checks on the wires between both interface ends.
// Assumes: All signals change only on the rising interface clock edge.
// Notes: Ownership is tracked from the grant code seen on the pins.
`timescale 1ns/1ns
module phy_link_checker (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [1:0] phy_ctl_o,
	input wire logic [1:0] phy_ctl_oe,
	input wire logic [7:0] phy_d_oe,
	input wire logic [1:0] llc_ctl_o,
	input wire logic [1:0] llc_ctl_oe,
	input wire logic [7:0] llc_d_oe,
	input wire logic link_request_line_o
);
	logic own_reg;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// The link end may drive only between a grant and the next drive.
	always_ff @(posedge sys_clk) begin
		if (srst)
			own_reg <= 1'b0;
		else if (phy_ctl_o == 2'b11 && |phy_ctl_oe)
			own_reg <= 1'b1;
		else if (|phy_ctl_oe || |phy_d_oe)
			own_reg <= 1'b0;
	end
	property p_rsvd;
		|llc_ctl_oe |-> llc_ctl_o != 2'b11;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("link drove the reserved code");
	property p_ctl_own;
		(phy_ctl_oe & llc_ctl_oe) == 2'b00;
	endproperty
	a_ctl_own: assert property (p_ctl_own)
		else $error("both ends drive the control pair");
	property p_d_own;
		(phy_d_oe & llc_d_oe) == 8'h00;
	endproperty
	a_d_own: assert property (p_d_own)
		else $error("both ends drive the data lanes");
	property p_grant;
		phy_ctl_o == 2'b11 && |phy_ctl_oe |=> phy_ctl_oe == 2'b00;
	endproperty
	a_grant: assert property (p_grant)
		else $error("control pair not released after grant");
	property p_link_own;
		|llc_ctl_oe || |llc_d_oe |-> own_reg;
	endproperty
	a_link_own: assert property (p_link_own)
		else $error("link end drove without a grant");
	property p_stat_len;
		$rose(phy_ctl_o == 2'b01) |->
			(phy_ctl_o == 2'b01)[*8] or (##[1:8] phy_ctl_o == 2'b10);
	endproperty
	a_stat_len: assert property (p_stat_len)
		else $error("status transfer cut short");
	property p_stat_gap;
		$fell(phy_ctl_o == 2'b01) |-> phy_ctl_o != 2'b11;
	endproperty
	a_stat_gap: assert property (p_stat_gap)
		else $error("grant straight after status");
	property p_quiet;
		$fell(srst) |-> phy_ctl_oe == 2'b00 && llc_ctl_oe == 2'b00 && !link_request_line_o;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("lines active after reset");
endmodule

/* File: testbench/phy_link_interface_requests_tb.sv */
// Purpose: Bench joining both interface ends through one link interface.
// Assumes: Data and status results leave the ends in order.
// Notes: The whole run repeats with output differentiation on.
`timescale 1ns/1ns
module phy_link_interface_requests_tb;
	import phy_link_pkg::*;
	logic sys_clk = 0, srst = 1, iso_sel = 1, stat_req = 0, diff_on;
	logic rx_in_valid = 0, rx_in_last = 0, arb_won = 0, req_valid = 0;
	logic tx_valid = 0, tx_last = 0;
	logic [15:0] stat_word = 0;
	logic [7:0] rx_in_data = 0, tx_data = 0, b;
	logic [2:0] req_kind = 0;
	logic [11:0] req_arg = 0;
	logic rx_in_ready_reg, bus_pend_reg, arb_skip_reg, arb_no_gap_reg;
	logic arb_gap_reg, fair_rule_reg, accel_en_reg, tx_valid_reg;
	logic null_tx_reg, req_ready_reg, tx_ready_reg, rx_valid_reg;
	logic stat_valid_reg;
	logic [2:0] speed_reg;
	logic [7:0] tx_data_reg, rx_data_reg;
	logic [15:0] stat_word_reg, lq[$], pq[$], sq[$];
	logic [2:0] sp[4] = '{SP_S100, SP_S200, SP_S400, 3'h5};
	integer seed = 32'hde2b8a75;
	int errors = 0, compares = 0, cycles = 0;
	link_if lk();
	assign diff_on = !iso_sel;
	phy_end_ctrl phy_end_ctrl_inst (.sys_clk(sys_clk),
		.srst(srst), .lk(lk), .iso_sel(iso_sel),
		.stat_req(stat_req), .stat_word(stat_word),
		.rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
		.rx_in_last(rx_in_last), .rx_in_ready_reg(rx_in_ready_reg),
		.arb_won(arb_won), .bus_pend_reg(bus_pend_reg),
		.arb_skip_reg(arb_skip_reg),
		.arb_no_gap_reg(arb_no_gap_reg),
		.arb_gap_reg(arb_gap_reg), .fair_rule_reg(fair_rule_reg),
		.speed_reg(speed_reg), .accel_en_reg(accel_en_reg),
		.tx_valid_reg(tx_valid_reg), .tx_data_reg(tx_data_reg),
		.null_tx_reg(null_tx_reg));
	link_end_ctrl link_end_ctrl_inst (.sys_clk(sys_clk),
		.srst(srst), .lk(lk), .diff_on(diff_on),
		.req_valid(req_valid), .req_kind(req_kind),
		.req_arg(req_arg), .req_ready_reg(req_ready_reg),
		.tx_valid(tx_valid), .tx_data(tx_data),
		.tx_last(tx_last), .tx_ready_reg(tx_ready_reg),
		.rx_valid_reg(rx_valid_reg), .rx_data_reg(rx_data_reg),
		.stat_valid_reg(stat_valid_reg),
		.stat_word_reg(stat_word_reg));
	phy_link_checker phy_link_checker_inst (.sys_clk(sys_clk),
		.srst(srst), .phy_ctl_o(lk.phy_ctl_o), .phy_ctl_oe(lk.phy_ctl_oe),
		.phy_d_oe(lk.phy_d_oe), .llc_ctl_o(lk.llc_ctl_o),
		.llc_ctl_oe(lk.llc_ctl_oe), .llc_d_oe(lk.llc_d_oe),
		.link_request_line_o(lk.link_request_line_o));
	// The clock toggles every half period.
	always #2 sys_clk = ~sys_clk;
	task automatic results();
		if (errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		compares++;
		if (e !== g) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic pop(string n, ref logic [15:0] q[$],
		input logic [15:0] g);
		chk(n, q.size() ? q.pop_front() : 16'hxxxx, g);
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Shifts one request out of the link end and waits until it is done.
	task automatic req(logic [2:0] k, logic [11:0] a);
		req_valid = 1;
		req_kind = k;
		req_arg = a;
		while (req_ready_reg !== 1) cyc(1);
		cyc(1);
		req_valid = 0;
		while (req_ready_reg !== 1) cyc(1);
	endtask
	// Each result leaving either end is matched to the oldest note.
	// Sampled mid-cycle, where the flopped pulses have settled.
	always @(negedge sys_clk) begin
		cycles++;
		if (rx_valid_reg === 1) pop("rx_data", lq, rx_data_reg);
		if (tx_valid_reg === 1) pop("tx_data", pq, tx_data_reg);
		if (stat_valid_reg === 1) pop("status", sq, stat_word_reg);
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end
	// Both passes run every scenario, the second with differentiation.
	initial begin
		for (int p = 0; p < 2; p++) begin
			iso_sel = (p == 0);
			srst = 1;
			cyc(8);
			srst = 0;
			cyc(2);
			chk("accel_rst", 1, accel_en_reg);
			rx_in_valid = 1;
			for (int i = 0; i < 6; i++) begin
				rx_in_data = 8'($random(seed));
				rx_in_last = (i == 5);
				while (rx_in_ready_reg !== 1) cyc(1);
				lq.push_back(rx_in_data);
				cyc(1);
			end
			rx_in_valid = 0;
			stat_word = 16'($random(seed));
			stat_req = 1;
			sq.push_back(stat_word);
			cyc(1);
			stat_req = 0;
			cyc(20);
			for (int i = 0; i < 3; i++) begin
				logic [3:0] a;
				a = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($random(seed));
				b = 8'($random(seed));
				req(RQ_WR, {a, b});
				req(RQ_RD, {8'h00, a});
				sq.push_back({a, b, 4'h0});
				cyc(24);
			end
			for (int i = 0; i < 2; i++) begin
				req(RQ_ACCEL, 12'(i));
				cyc(6);
				chk("accel", 16'(i), accel_en_reg);
			end
			req(RQ_RSVD, 12'hfff);
			cyc(12);
			chk("rsvd_pend", 0, bus_pend_reg);
			chk("rsvd_acc", 1, accel_en_reg);
			for (int k = 0; k < 4; k++) begin
				req(3'(k), {9'h000, sp[k]});
				for (int i = 0; i < 30 && bus_pend_reg !== 1; i++) cyc(1);
				chk("pend_set", 1, bus_pend_reg);
				chk("skip", k == 0, arb_skip_reg);
				chk("no_gap", k == 1, arb_no_gap_reg);
				chk("gap", k > 1, arb_gap_reg);
				chk("fair", k == 3, fair_rule_reg);
				chk("speed", sp[k], speed_reg);
				arb_won = 1;
				cyc(1);
				arb_won = 0;
				tx_valid = 1;
				for (int i = 0; i < 2; i++) begin
					tx_data = 8'($random(seed));
					tx_last = (i == 1);
					while (tx_ready_reg !== 1) cyc(1);
					if (k < 3) pq.push_back(tx_data);
					cyc(1);
				end
				tx_valid = 0;
				chk("null", k == 3, null_tx_reg);
				cyc(12);
				chk("pend_clr", 0, bus_pend_reg);
			end
		end
		chk("left", 0, 16'(lq.size() + pq.size() + sq.size()));
		results();
	end
endmodule
